// ==== src/ldc_regs.svh ====
// Purpose: register offsets, field positions, reset values and timing counts
// Assumes: APB byte addresses, one aligned 32-bit word per register
// Notes: included by the ldo control block
`ifndef LDC_REGS_SVH
`define LDC_REGS_SVH

`define LDC_CH_CFG_A 12'h000
`define LDC_CH_CFG_B 12'h004
`define LDC_CH_CFG_C 12'h008
`define LDC_CH_CFG_D 12'h00C
`define LDC_STATUS 12'h010
`define LDC_IRQ_STAT 12'h014
`define LDC_IRQ_MASK 12'h018

// channel config field positions
`define LDC_F_VCODE_LSB 0
`define LDC_F_ON 8
`define LDC_F_BLEED 9
`define LDC_F_LOW_QUIESCENT_SELECT 10
`define LDC_F_FLTEN 11
`define LDC_F_WAIT_LSB 12

// status word: power-good [3:0], enabled [7:4], output live [11:8], pending [15:12]
`define LDC_VCODE_RST 6'h18
`define LDC_WAIT_RST 3'h0

// one millisecond at 250 MHz: 1 ms / 4 ns
`define LDC_CLK_PERIOD_PS 4000
`define LDC_MS_PS 1000000000
`define LDC_MS_CYCLES (`LDC_MS_PS / `LDC_CLK_PERIOD_PS)

`endif

// ==== src/ldc_pkg.sv ====
// Purpose: types for the ldo control block
// Assumes: four channels
// Notes: constants live in ldc_regs.svh
package ldc_pkg;
  typedef enum logic [1:0] {
    CH_OFF,
    CH_WAIT,
    CH_ON
  } ldc_ch_state_e;
  typedef logic [5:0] ldc_vcode_t;
  typedef logic [2:0] ldc_wait_t;
endpackage

// ==== src/ldc_channel.sv ====
// Purpose: one ldo channel sequencer with turn-on delay
// Assumes: on_rise/on_fall are one-cycle pulses from written edges
// Notes: ms tick is shared
`timescale 1ns/10ps
`include "ldc_regs.svh"
module ldc_channel
  import ldc_pkg::*;
(
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic ms_tick_in,
  input wire logic on_rise_in,
  input wire logic on_fall_in,
  input wire ldc_wait_t wait_code_in,
  output logic live_out
);
  ldc_ch_state_e state_reg, state_next;
  logic [7:0] ms_left_reg, ms_left_next;

  always_comb begin
    state_next = state_reg;
    ms_left_next = ms_left_reg;
    unique case (state_reg)
      CH_OFF: begin
        if (on_rise_in) begin
          if (wait_code_in == 3'h0) begin
            state_next = CH_ON;
          end else begin
            // 2^code ms; +1 because the first tick may be partial
            ms_left_next = 8'(8'h01 << wait_code_in) + 8'h01;
            state_next = CH_WAIT;
          end
        end
      end
      CH_WAIT: begin
        if (on_fall_in) begin
          state_next = CH_OFF;
        end else if (ms_tick_in) begin
          if (ms_left_reg == 8'h01) begin
            state_next = CH_ON;
          end else begin
            ms_left_next = ms_left_reg - 8'h01;
          end
        end
      end
      CH_ON: begin
        if (on_fall_in) begin
          state_next = CH_OFF;
        end
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_reg <= CH_OFF;
      ms_left_reg <= 8'h00;
    end else begin
      state_reg <= state_next;
      ms_left_reg <= ms_left_next;
    end
  end

  assign live_out = (state_reg == CH_ON);
endmodule

// ==== src/ldc_top.sv ====
// Purpose: control and status for four ldo channels, APB slave
// Assumes: analog side gives per-channel power-good level in sync with clock
// Notes: interrupt line is active low and registered
//
// Overview of operation
// - channels start at default voltage code; software may rewrite each code.
// - channel turns on only on 0-to-1 edge of its enable bit.
// - channel turns off only on 1-to-0 edge of its enable bit.
// - each channel waits its own startup delay before output rises.
// - wait code 0 means none; 1..7 mean 2,4,...,128 ms.
// - voltage code is six bits: range in upper three, step lower three.
// - bleed bit set discharges output while channel is disabled.
// - low-quiescent bit set selects reduced quiescent mode.
// - readable power-good flag per channel, zero when output is low.
// - enabled channel fault below threshold pulls interrupt line low.
// - interrupt holds until channel off or good, and status or its own config word was read.
`timescale 1ns/10ps
`include "ldc_regs.svh"
module ldc_top
  import ldc_pkg::*;
(
  input wire logic CORE_CLK_IN,
  input wire logic RSTN_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [11:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  input wire logic [3:0] POWER_GOOD_IN,
  output logic [3:0] CH_ENABLE_OUT,
  output logic [23:0] OUTPUT_VOLTAGE_CODE_OUT,
  output logic [3:0] OUTPUT_BLEED_OUT,
  output logic [3:0] LOW_QUIESCENT_OUT,
  output logic INTERRUPT_REQUEST_N_OUT,
  output logic IRQ_OUT
);
  logic [5:0] vcode_reg [4];
  logic [5:0] vcode_next [4];
  logic [3:0] on_reg, on_next;
  logic [3:0] bleed_reg, bleed_next;
  logic [3:0] low_quiescent_select_reg, low_quiescent_select_next;
  logic [3:0] flten_reg, flten_next;
  logic [2:0] wait_reg [4];
  logic [2:0] wait_next [4];
  logic [3:0] pend_reg, pend_next;
  logic [3:0] read_seen_reg, read_seen_next;
  logic [3:0] istat_reg, istat_next;
  logic [3:0] imask_reg, imask_next;
  logic [31:0] prdata_reg, prdata_next;
  logic pready_reg, pready_next;
  logic pslverr_reg, pslverr_next;
  logic interrupt_request_n_reg, interrupt_request_n_next;
  logic irq_reg, irq_next;
  logic [17:0] ms_cnt_reg, ms_cnt_next;
  logic ms_tick;
  logic [3:0] on_rise, on_fall, live;
  logic [3:0] good_reg;
  logic wr_acc, rd_acc, addr_ok;

  assign wr_acc = PSEL_IN && PENABLE_IN && PWRITE_IN && !pready_reg;
  assign rd_acc = PSEL_IN && PENABLE_IN && !PWRITE_IN && !pready_reg;
  assign addr_ok = (PADDR_IN <= `LDC_IRQ_MASK) && (PADDR_IN[1:0] == 2'h0);

  // millisecond time base for startup delays
  assign ms_tick = (ms_cnt_reg == 18'(`LDC_MS_CYCLES - 1));
  always_comb begin
    ms_cnt_next = ms_tick ? 18'h00000 : ms_cnt_reg + 18'h00001;
  end

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : gen_ch
      ldc_channel u_ch (
        .clk_in(CORE_CLK_IN),
        .rstn_in(RSTN_IN),
        .ms_tick_in(ms_tick),
        .on_rise_in(on_rise[g]),
        .on_fall_in(on_fall[g]),
        .wait_code_in(wait_reg[g]),
        .live_out(live[g])
      );
    end
  endgenerate

  // register writes and enable edge detection
  always_comb begin
    on_next = on_reg;
    bleed_next = bleed_reg;
    low_quiescent_select_next = low_quiescent_select_reg;
    flten_next = flten_reg;
    imask_next = imask_reg;
    on_rise = 4'h0;
    on_fall = 4'h0;
    for (int i = 0; i < 4; i++) begin
      vcode_next[i] = vcode_reg[i];
      wait_next[i] = wait_reg[i];
      if (wr_acc && PADDR_IN == 12'(i * 4)) begin
        vcode_next[i] = PWDATA_IN[`LDC_F_VCODE_LSB +: 6];
        wait_next[i] = PWDATA_IN[`LDC_F_WAIT_LSB +: 3];
        bleed_next[i] = PWDATA_IN[`LDC_F_BLEED];
        low_quiescent_select_next[i] = PWDATA_IN[`LDC_F_LOW_QUIESCENT_SELECT];
        flten_next[i] = PWDATA_IN[`LDC_F_FLTEN];
        on_next[i] = PWDATA_IN[`LDC_F_ON];
        on_rise[i] = !on_reg[i] && PWDATA_IN[`LDC_F_ON];
        on_fall[i] = on_reg[i] && !PWDATA_IN[`LDC_F_ON];
      end
    end
    if (wr_acc && PADDR_IN == `LDC_IRQ_MASK) begin
      imask_next = PWDATA_IN[3:0];
    end
  end

  // fault tracking: pending holds until (off or good) and status or own config word read
  always_comb begin
    pend_next = pend_reg;
    read_seen_next = read_seen_reg;
    istat_next = istat_reg;
    for (int i = 0; i < 4; i++) begin
      if (rd_acc && (PADDR_IN == `LDC_STATUS || PADDR_IN == 12'(i * 4))) begin
        read_seen_next[i] = 1'b1;
      end
      if (live[i] && !good_reg[i] && flten_reg[i]) begin
        pend_next[i] = 1'b1;
        // only a new fault forgets earlier reads; a read during the fault counts
        if (!pend_reg[i]) begin
          read_seen_next[i] = 1'b0;
        end
      end else if (pend_reg[i] && read_seen_reg[i] && (!live[i] || good_reg[i])) begin
        pend_next[i] = 1'b0;
      end
      if (wr_acc && PADDR_IN == `LDC_IRQ_STAT && PWDATA_IN[i]) begin
        istat_next[i] = 1'b0;
      end
      if (live[i] && !good_reg[i] && flten_reg[i] && !pend_reg[i]) begin
        istat_next[i] = 1'b1;
      end
    end
    interrupt_request_n_next = ~(|pend_next);
    irq_next = |(istat_next & imask_next);
  end

  // apb read mux and one wait state answer
  always_comb begin
    prdata_next = 32'h00000000;
    pready_next = PSEL_IN && PENABLE_IN && !pready_reg;
    pslverr_next = PSEL_IN && PENABLE_IN && !pready_reg && !addr_ok;
    if (rd_acc && addr_ok) begin
      for (int i = 0; i < 4; i++) begin
        if (PADDR_IN == 12'(i * 4)) begin
          prdata_next[`LDC_F_VCODE_LSB +: 6] = vcode_reg[i];
          prdata_next[`LDC_F_ON] = on_reg[i];
          prdata_next[`LDC_F_BLEED] = bleed_reg[i];
          prdata_next[`LDC_F_LOW_QUIESCENT_SELECT] = low_quiescent_select_reg[i];
          prdata_next[`LDC_F_FLTEN] = flten_reg[i];
          prdata_next[`LDC_F_WAIT_LSB +: 3] = wait_reg[i];
        end
      end
      if (PADDR_IN == `LDC_STATUS) begin
        // flag is zero whenever channel output is not up and good
        prdata_next[15:0] = {pend_reg, live, on_reg, good_reg & live};
      end
      if (PADDR_IN == `LDC_IRQ_STAT) begin
        prdata_next[3:0] = istat_reg;
      end
      if (PADDR_IN == `LDC_IRQ_MASK) begin
        prdata_next[3:0] = imask_reg;
      end
    end
  end

  always_ff @(posedge CORE_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      for (int i = 0; i < 4; i++) begin
        vcode_reg[i] <= `LDC_VCODE_RST;
        wait_reg[i] <= `LDC_WAIT_RST;
      end
      on_reg <= 4'h0;
      bleed_reg <= 4'h0;
      low_quiescent_select_reg <= 4'h0;
      flten_reg <= 4'h0;
      imask_reg <= 4'h0;
      pend_reg <= 4'h0;
      read_seen_reg <= 4'h0;
      istat_reg <= 4'h0;
      prdata_reg <= 32'h00000000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      interrupt_request_n_reg <= 1'b1;
      irq_reg <= 1'b0;
      ms_cnt_reg <= 18'h00000;
      good_reg <= 4'h0;
      CH_ENABLE_OUT <= 4'h0;
      OUTPUT_VOLTAGE_CODE_OUT <= 24'h000000;
      OUTPUT_BLEED_OUT <= 4'h0;
      LOW_QUIESCENT_OUT <= 4'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        vcode_reg[i] <= vcode_next[i];
        wait_reg[i] <= wait_next[i];
        OUTPUT_VOLTAGE_CODE_OUT[i*6 +: 6] <= vcode_reg[i];
      end
      on_reg <= on_next;
      bleed_reg <= bleed_next;
      low_quiescent_select_reg <= low_quiescent_select_next;
      flten_reg <= flten_next;
      imask_reg <= imask_next;
      pend_reg <= pend_next;
      read_seen_reg <= read_seen_next;
      istat_reg <= istat_next;
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      interrupt_request_n_reg <= interrupt_request_n_next;
      irq_reg <= irq_next;
      ms_cnt_reg <= ms_cnt_next;
      good_reg <= POWER_GOOD_IN;
      CH_ENABLE_OUT <= live;
      OUTPUT_BLEED_OUT <= bleed_reg & ~live;
      LOW_QUIESCENT_OUT <= low_quiescent_select_reg;
    end
  end

  assign PRDATA_OUT = prdata_reg;
  assign PREADY_OUT = pready_reg;
  assign PSLVERR_OUT = pslverr_reg;
  assign INTERRUPT_REQUEST_N_OUT = interrupt_request_n_reg;
  assign IRQ_OUT = irq_reg;
endmodule

// ==== bench/ldc_top_props.sv ====
// Purpose: concurrent checks on the ldo control block ports
// Assumes: one clock domain, async active-low reset
// Notes: bound to ldc_top below
`timescale 1ns/10ps
`include "ldc_regs.svh"
module ldc_top_props (
  input wire logic CORE_CLK_IN,
  input wire logic RSTN_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [11:0] PADDR_IN,
  input wire logic [31:0] PRDATA_OUT,
  input wire logic PREADY_OUT,
  input wire logic PSLVERR_OUT,
  input wire logic [3:0] POWER_GOOD_IN,
  input wire logic [3:0] CH_ENABLE_OUT,
  input wire logic [23:0] OUTPUT_VOLTAGE_CODE_OUT,
  input wire logic [3:0] OUTPUT_BLEED_OUT,
  input wire logic [3:0] LOW_QUIESCENT_OUT,
  input wire logic INTERRUPT_REQUEST_N_OUT
);
  logic wr_acc;
  logic [3:0] cause;
  assign wr_acc = PSEL_IN & PENABLE_IN & PWRITE_IN;
  assign cause = CH_ENABLE_OUT & ~POWER_GOOD_IN;
  default clocking cb @(posedge CORE_CLK_IN);
  endclocking
  default disable iff (!RSTN_IN);
  property p_vcode_hold;
    !$stable(OUTPUT_VOLTAGE_CODE_OUT) |->
      $past(wr_acc) || $past(wr_acc, 2) || $past(!RSTN_IN, 2);
  endproperty
  a_vcode_hold: assert property (p_vcode_hold) else $error("code moved without write");
  property p_low_quiescent_select_hold;
    !$stable(LOW_QUIESCENT_OUT) |-> $past(wr_acc) || $past(wr_acc, 2);
  endproperty
  a_low_quiescent_select_hold: assert property (p_low_quiescent_select_hold) else $error("low_quiescent_select moved without write");
  property p_bleed_off;
    (OUTPUT_BLEED_OUT & CH_ENABLE_OUT & $past(CH_ENABLE_OUT)) == 4'h0;
  endproperty
  a_bleed_off: assert property (p_bleed_off) else $error("bleed on live channel");
  property p_irq_cause;
    $fell(INTERRUPT_REQUEST_N_OUT) |-> ($past(cause, 2) | $past(cause, 3)) != 4'h0;
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq without fault");
  property p_pg_live;
    PREADY_OUT && !PSLVERR_OUT && !PWRITE_IN && PADDR_IN == `LDC_STATUS |->
      (PRDATA_OUT[3:0] & ~PRDATA_OUT[11:8]) == 4'h0;
  endproperty
  a_pg_live: assert property (p_pg_live) else $error("good flag on dead channel");
  property p_ready_pulse;
    PREADY_OUT |=> !PREADY_OUT;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready longer than one cycle");
  property p_ready_cause;
    $rose(PREADY_OUT) |-> $past(PSEL_IN && PENABLE_IN);
  endproperty
  a_ready_cause: assert property (p_ready_cause) else $error("ready without access");
  property p_err_zero;
    PSLVERR_OUT |-> PREADY_OUT && PRDATA_OUT == 32'h0;
  endproperty
  a_err_zero: assert property (p_err_zero) else $error("error without ready or with data");
endmodule
bind ldc_top ldc_top_props ldc_top_props_i (.CORE_CLK_IN(CORE_CLK_IN), .RSTN_IN(RSTN_IN),
  .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN),
  .PRDATA_OUT(PRDATA_OUT), .PREADY_OUT(PREADY_OUT), .PSLVERR_OUT(PSLVERR_OUT),
  .POWER_GOOD_IN(POWER_GOOD_IN), .CH_ENABLE_OUT(CH_ENABLE_OUT),
  .OUTPUT_VOLTAGE_CODE_OUT(OUTPUT_VOLTAGE_CODE_OUT), .OUTPUT_BLEED_OUT(OUTPUT_BLEED_OUT),
  .LOW_QUIESCENT_OUT(LOW_QUIESCENT_OUT), .INTERRUPT_REQUEST_N_OUT(INTERRUPT_REQUEST_N_OUT));

// ==== bench/ldc_host_model.sv ====
// Purpose: host processor model, APB master
// Assumes: signals change just after a rising edge
// Notes: waits for ready with no cycle count of its own
`timescale 1ns/10ps
module ldc_host_model (
  input wire logic clk_in,
  input wire logic pready_in,
  input wire logic [31:0] prdata_in,
  input wire logic pslverr_in,
  output logic psel_out,
  output logic penable_out,
  output logic pwrite_out,
  output logic [11:0] paddr_out,
  output logic [31:0] pwdata_out
);
  initial begin
    {psel_out, penable_out, pwrite_out} = 3'h0;
    paddr_out = 12'h000;
    pwdata_out = 32'h0;
  end
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic e);
    @(posedge clk_in);
    psel_out <= 1'b1;
    pwrite_out <= w;
    paddr_out <= a;
    pwdata_out <= d;
    @(posedge clk_in);
    penable_out <= 1'b1;
    do @(posedge clk_in); while (pready_in !== 1'b1);
    q = prdata_in;
    e = pslverr_in;
    psel_out <= 1'b0;
    penable_out <= 1'b0;
  endtask
endmodule

// ==== bench/ldc_top_tb.sv ====
// Purpose: self-checking bench for the ldo control block
// Assumes: code 1 wait is far longer than the run watches
// Notes: one task per scenario
`timescale 1ns/10ps
`include "ldc_regs.svh"
module ldc_top_tb;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [3:0] pg = 4'hF;
  logic psel, penable, pwrite, pready, pslverr, interrupt_request_n, irq, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [3:0] live, bleed, low_quiescent_select;
  logic [23:0] vcode;
  int errors = 0;
  int num_checks = 0;
  always #2 clk = ~clk;
  ldc_host_model ldc_host_model_i (.clk_in(clk), .pready_in(pready), .prdata_in(prdata),
    .pslverr_in(pslverr), .psel_out(psel), .penable_out(penable), .pwrite_out(pwrite),
    .paddr_out(paddr), .pwdata_out(pwdata));
  ldc_top ldc_top_i (.CORE_CLK_IN(clk), .RSTN_IN(rstn), .PSEL_IN(psel), .PENABLE_IN(penable),
    .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
    .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .POWER_GOOD_IN(pg), .CH_ENABLE_OUT(live),
    .OUTPUT_VOLTAGE_CODE_OUT(vcode), .OUTPUT_BLEED_OUT(bleed), .LOW_QUIESCENT_OUT(low_quiescent_select),
    .INTERRUPT_REQUEST_N_OUT(interrupt_request_n), .IRQ_OUT(irq));
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
    num_checks++;
    if (s !== x) begin
      errors++;
      $display("CHECK FAILED %s exp %h seen %h", n, x, s);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    ldc_host_model_i.xfer(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [11:0] a);
    ldc_host_model_i.xfer(1'b0, a, 32'h0, q, e);
  endtask
  task automatic t_reset;
    for (int i = 0; i < 4; i++) begin
      rd(12'(4 * i));
      chk("cfg_reset", q, 32'h18);
    end
    chk("vcode_reset", vcode, {4{6'h18}});
    chk("interrupt_request_n_reset", interrupt_request_n, 1'b1);
    $display("t_reset done");
  endtask
  task automatic t_vcode;
    wr(`LDC_CH_CFG_B, 32'h3F);
    rd(`LDC_CH_CFG_B);
    chk("cfg_b", q, 32'h3F);
    chk("vcode_out", vcode, {12'h618, 6'h3F, 6'h18});
    $display("t_vcode done");
  endtask
  task automatic t_onoff;
    // write 0 then 1 and 1 then 0: only edges switch the channel
    wr(`LDC_CH_CFG_C, 32'h618);
    repeat (3) @(posedge clk);
    chk("bleed_off", bleed[2], 1'b1);
    chk("low_quiescent_select_set", low_quiescent_select[2], 1'b1);
    wr(`LDC_CH_CFG_C, 32'h718);
    repeat (3) @(posedge clk);
    chk("live_on", live[2], 1'b1);
    chk("bleed_live", bleed[2], 1'b0);
    wr(`LDC_CH_CFG_C, 32'h718);
    repeat (3) @(posedge clk);
    chk("live_rewrite", live[2], 1'b1);
    wr(`LDC_CH_CFG_C, 32'h218);
    repeat (3) @(posedge clk);
    chk("live_off", live[2], 1'b0);
    chk("bleed_again", bleed[2], 1'b1);
    chk("low_quiescent_select_clr", low_quiescent_select[2], 1'b0);
    wr(`LDC_CH_CFG_C, 32'h018);
    repeat (3) @(posedge clk);
    chk("bleed_clr", bleed[2], 1'b0);
    $display("t_onoff done");
  endtask
  task automatic t_wait;
    wr(`LDC_CH_CFG_D, 32'h1018);
    wr(`LDC_CH_CFG_D, 32'h1118);
    repeat (1000) @(posedge clk);
    chk("wait_live", live[3], 1'b0);
    wr(`LDC_CH_CFG_D, 32'h1018);
    repeat (3) @(posedge clk);
    chk("wait_cancel", live[3], 1'b0);
    $display("t_wait done");
  endtask
  task automatic t_fault;
    wr(`LDC_CH_CFG_A, 32'h918);
    repeat (3) @(posedge clk);
    rd(`LDC_STATUS);
    chk("status_good", q[11:0], 12'h111);
    pg <= 4'hE;
    repeat (4) @(posedge clk);
    chk("interrupt_request_n_fault", interrupt_request_n, 1'b0);
    pg <= 4'hF;
    repeat (6) @(posedge clk);
    chk("interrupt_request_n_unread", interrupt_request_n, 1'b0);
    rd(`LDC_STATUS);
    chk("flag_back", q[0], 1'b1);
    repeat (3) @(posedge clk);
    chk("interrupt_request_n_release", interrupt_request_n, 1'b1);
    rd(`LDC_IRQ_STAT);
    chk("stat_set", q[3:0], 4'h1);
    chk("irq_masked", irq, 1'b0);
    wr(`LDC_IRQ_MASK, 32'h1);
    repeat (2) @(posedge clk);
    chk("irq_on", irq, 1'b1);
    wr(`LDC_IRQ_STAT, 32'h1);
    repeat (2) @(posedge clk);
    chk("irq_clr", irq, 1'b0);
    pg <= 4'hE;
    repeat (3) @(posedge clk);
    rd(`LDC_STATUS);
    chk("flag_low", q[0], 1'b0);
    wr(`LDC_CH_CFG_A, 32'h818);
    repeat (4) @(posedge clk);
    chk("interrupt_request_n_off", interrupt_request_n, 1'b1);
    pg <= 4'hF;
    $display("t_fault done");
  endtask
  task automatic t_err;
    wr(12'h01C, 32'hFFFF);
    chk("wr_err", e, 1'b1);
    rd(12'h002);
    chk("rd_err", {e, q}, {1'b1, 32'h0});
    $display("t_err done");
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    final_report;
  end
  initial begin
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    t_reset;
    t_vcode;
    t_onoff;
    t_wait;
    t_fault;
    t_err;
    final_report;
  end
endmodule
